/* File: design/cpuet_timing.sv */
/*
 * Execution state timing: takes an instruction form and access
 * conditions, computes the total states, then counts them out.
 * Assumes all inputs are driven by logic on core_clk_i.
 */
// Function
// - Total states are the sum over six cycle classes of count times states per cycle.
// - Fetch states depend on memory, module bus width, external bus and wait states.
// - Branch address read and stack cycles take as many states as a fetch.
// - Byte data access takes 3 on an 8-bit module, 2 or 3 + m externally on 8 bits.
// - Word data access takes 6 on an 8-bit module, 4 or 6 + 2m externally on 8 bits.
// - Each internal operation cycle takes exactly one state.
// - m is the wait count, adding m per byte access and 2m per 8-bit word access.
// - Add takes 1 fetch for byte immediate or any register form, 2 for 16-bit immediate and 3 for 32-bit immediate.
// - Add small constant, add with extend and and to condition code take one fetch.
// - Bit-and takes 1 fetch on a register, else 2 fetches plus 1 byte data access.
// - Every 8-bit displacement branch takes 2 fetches whether taken or not.
module cpuet_timing #(
    parameter int STATE_DIV = 1
) (
    input  wire logic                             core_clk_i,
    input  wire logic                             arst_n_i,
    input  wire logic                             start_i,
    input  wire cpuet_pkg::cpuet_instr_t          instr_i,
    input  wire cpuet_pkg::cpuet_cond_t           fetch_cond_i,
    input  wire cpuet_pkg::cpuet_cond_t           branch_cond_i,
    input  wire cpuet_pkg::cpuet_cond_t           stack_cond_i,
    input  wire cpuet_pkg::cpuet_cond_t           data_cond_i,
    input  wire logic [cpuet_pkg::WAIT_W-1:0]     wait_m_i,
    output logic      [cpuet_pkg::TOT_W-1:0]      states_o,
    output logic      [cpuet_pkg::CNT_W-1:0]      fetch_cnt_o,
    output logic      [cpuet_pkg::CNT_W-1:0]      byte_cnt_o,
    output logic                                  busy_o,
    output logic                                  state_tick_o,
    output logic                                  done_o,
    output logic                                  err_o
);
    import cpuet_pkg::*;

    localparam int DIV_W = (STATE_DIV > 1) ? $clog2(STATE_DIV) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(STATE_DIV - 1);
    localparam logic [DIV_W-1:0] DIV_ZERO = '0;
    localparam logic [TOT_W-1:0] TOT_ONE  = TOT_W'(1);

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CPUET_IDLE,
        CPUET_CALC,
        CPUET_RUN
    } cpuet_phase_t;

    typedef struct packed {
        logic [CNT_W-1:0] i;
        logic [CNT_W-1:0] j;
        logic [CNT_W-1:0] k;
        logic [CNT_W-1:0] l;
        logic [CNT_W-1:0] m;
        logic [CNT_W-1:0] n;
        logic             bad;
    } cpuet_cnt_t;

    typedef struct packed {
        cpuet_phase_t        phase;
        cpuet_instr_t        instr;
        cpuet_cond_t         fetch_cond;
        cpuet_cond_t         branch_cond;
        cpuet_cond_t         stack_cond;
        cpuet_cond_t         data_cond;
        logic [WAIT_W-1:0]   wait_m;
        logic [TOT_W-1:0]    total;
        logic [TOT_W-1:0]    remain;
        logic [DIV_W-1:0]    div;
        logic [CNT_W-1:0]    fetch_cnt;
        logic [CNT_W-1:0]    byte_cnt;
        logic                busy;
        logic                tick;
        logic                done;
        logic                err;
    } cpuet_st_t;

    cpuet_st_t st_r;
    cpuet_st_t st_nxt;

    // ------------------------------------------------------------------
    // Cycle counts per instruction
    // ------------------------------------------------------------------
    function automatic cpuet_cnt_t cycle_counts(input cpuet_instr_t ins);
        cpuet_cnt_t c;
        c     = '0;
        c.bad = 1'b0;
        unique case (ins)
            CPUET_ADD_B_IMM, CPUET_ADD_B_REG, CPUET_ADD_W_REG,
            CPUET_ADD_L_REG:
                c.i = CPUET_CNT_ONE;
            CPUET_ADD_W_IMM:
                c.i = CPUET_CNT_TWO;
            CPUET_ADD_L_IMM:
                c.i = CPUET_CNT_THREE;
            CPUET_ADD_SMALL_CONSTANT, CPUET_ADD_WITH_EXTEND_IMM,
            CPUET_ADD_WITH_EXTEND_REG, CPUET_AND_TO_CONDITION_CODE:
                c.i = CPUET_CNT_ONE;
            CPUET_AND_B_IMM, CPUET_AND_B_REG, CPUET_AND_W_REG:
                c.i = CPUET_CNT_ONE;
            CPUET_AND_W_IMM, CPUET_AND_L_REG:
                c.i = CPUET_CNT_TWO;
            CPUET_AND_L_IMM:
                c.i = CPUET_CNT_THREE;
            CPUET_BIT_AND_REG:
                c.i = CPUET_CNT_ONE;
            CPUET_BIT_AND_IND, CPUET_BIT_AND_ABS: begin
                c.i = CPUET_CNT_TWO;
                c.l = CPUET_CNT_ONE;
            end
            CPUET_BRANCH_D8:
                c.i = CPUET_CNT_TWO;
            default:
                c.bad = 1'b1;
        endcase
        return c;
    endfunction

    // ------------------------------------------------------------------
    // Weighted term
    // ------------------------------------------------------------------
    function automatic logic [TOT_W-1:0] weigh(
        input logic [CNT_W-1:0] cnt,
        input logic [ST_W-1:0]  states
    );
        logic [2*TOT_W-1:0] p;
        p = (2*TOT_W)'(cnt) * (2*TOT_W)'(states);
        return p[TOT_W-1:0];
    endfunction

    // ------------------------------------------------------------------
    // Condition fault on a used class
    // ------------------------------------------------------------------
    function automatic logic class_bad(
        input logic             bad,
        input logic [CNT_W-1:0] cnt
    );
        return bad && (cnt != CPUET_CNT_NONE);
    endfunction

    // ------------------------------------------------------------------
    // States per cycle lookups
    // ------------------------------------------------------------------
    logic [ST_W-1:0] s_fetch;
    logic [ST_W-1:0] s_branch;
    logic [ST_W-1:0] s_stack;
    logic [ST_W-1:0] s_byte;
    logic [ST_W-1:0] s_word;
    logic            bad_fetch;
    logic            bad_branch;
    logic            bad_stack;
    logic            bad_data;

    cpuet_cycle_states u_fetch (
        .cond_i         (st_r.fetch_cond),
        .wait_m_i       (st_r.wait_m),
        .fetch_states_o (s_fetch),
        .byte_states_o  (),
        .word_states_o  (),
        .bad_cond_o     (bad_fetch)
    );

    cpuet_cycle_states u_branch (
        .cond_i         (st_r.branch_cond),
        .wait_m_i       (st_r.wait_m),
        .fetch_states_o (s_branch),
        .byte_states_o  (),
        .word_states_o  (),
        .bad_cond_o     (bad_branch)
    );

    cpuet_cycle_states u_stack (
        .cond_i         (st_r.stack_cond),
        .wait_m_i       (st_r.wait_m),
        .fetch_states_o (s_stack),
        .byte_states_o  (),
        .word_states_o  (),
        .bad_cond_o     (bad_stack)
    );

    cpuet_cycle_states u_data (
        .cond_i         (st_r.data_cond),
        .wait_m_i       (st_r.wait_m),
        .fetch_states_o (),
        .byte_states_o  (s_byte),
        .word_states_o  (s_word),
        .bad_cond_o     (bad_data)
    );

    // ------------------------------------------------------------------
    // Total and validity
    // ------------------------------------------------------------------
    cpuet_cnt_t       cnt;
    logic [TOT_W-1:0] sum;
    logic             bad_any;

    always_comb begin
        cnt = cycle_counts(st_r.instr);
        sum = weigh(cnt.i, s_fetch)
            + weigh(cnt.j, s_branch)
            + weigh(cnt.k, s_stack)
            + weigh(cnt.l, s_byte)
            + weigh(cnt.m, s_word)
            + weigh(cnt.n, CPUET_S_INTERNAL);
        bad_any = cnt.bad
                | class_bad(bad_fetch, cnt.i)
                | class_bad(bad_branch, cnt.j)
                | class_bad(bad_stack, cnt.k)
                | class_bad(bad_data, cnt.l)
                | class_bad(bad_data, cnt.m);
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt      = st_r;
        st_nxt.tick = 1'b0;
        st_nxt.done = 1'b0;
        unique case (st_r.phase)
            CPUET_IDLE: begin
                if (start_i) begin
                    st_nxt.phase       = CPUET_CALC;
                    st_nxt.instr       = instr_i;
                    st_nxt.fetch_cond  = fetch_cond_i;
                    st_nxt.branch_cond = branch_cond_i;
                    st_nxt.stack_cond  = stack_cond_i;
                    st_nxt.data_cond   = data_cond_i;
                    st_nxt.wait_m      = wait_m_i;
                    st_nxt.busy        = 1'b1;
                    st_nxt.err         = 1'b0;
                end
            end
            CPUET_CALC: begin
                st_nxt.fetch_cnt = cnt.i;
                st_nxt.byte_cnt  = cnt.l;
                if (bad_any) begin
                    st_nxt.phase = CPUET_IDLE;
                    st_nxt.total = '0;
                    st_nxt.busy  = 1'b0;
                    st_nxt.done  = 1'b1;
                    st_nxt.err   = 1'b1;
                end else begin
                    st_nxt.phase  = CPUET_RUN;
                    st_nxt.total  = sum;
                    st_nxt.remain = sum;
                    st_nxt.div    = DIV_ZERO;
                end
            end
            CPUET_RUN: begin
                if (st_r.div == DIV_LAST) begin
                    st_nxt.div    = DIV_ZERO;
                    st_nxt.tick   = 1'b1;
                    st_nxt.remain = st_r.remain - TOT_ONE;
                    if (st_r.remain == TOT_ONE) begin
                        st_nxt.phase = CPUET_IDLE;
                        st_nxt.busy  = 1'b0;
                        st_nxt.done  = 1'b1;
                    end
                end else begin
                    st_nxt.div = st_r.div + DIV_W'(1);
                end
            end
            default: begin
                st_nxt.phase  = CPUET_IDLE;
                st_nxt.busy   = 1'b0;
                st_nxt.remain = '0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r       <= '0;
            st_r.phase <= CPUET_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign states_o     = st_r.total;
    assign fetch_cnt_o  = st_r.fetch_cnt;
    assign byte_cnt_o   = st_r.byte_cnt;
    assign busy_o       = st_r.busy;
    assign state_tick_o = st_r.tick;
    assign done_o       = st_r.done;
    assign err_o        = st_r.err;

endmodule // cpuet_timing

/* File: include/cpuet_pkg.sv */
/*
 * Shared constants and types for the execution state timing block.
 * Assumes a single core clock; the instruction and access codes are
 * driven from logic in the same clock domain.
 */
package cpuet_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int CNT_W  = 2;   // Cycle count per class
    localparam int ST_W   = 6;   // States per cycle
    localparam int TOT_W  = 10;  // Total states
    localparam int WAIT_W = 4;   // Wait state count m

    // ------------------------------------------------------------------
    // Access conditions
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        CPUET_ONCHIP_MEM,
        CPUET_MOD_8BIT,
        CPUET_MOD_16BIT,
        CPUET_EXT8_2STATE,
        CPUET_EXT8_3STATE,
        CPUET_EXT16_2STATE,
        CPUET_EXT16_3STATE
    } cpuet_cond_t;

    // ------------------------------------------------------------------
    // Instruction forms
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        CPUET_ADD_B_IMM,
        CPUET_ADD_B_REG,
        CPUET_ADD_W_IMM,
        CPUET_ADD_W_REG,
        CPUET_ADD_L_IMM,
        CPUET_ADD_L_REG,
        CPUET_ADD_SMALL_CONSTANT,
        CPUET_ADD_WITH_EXTEND_IMM,
        CPUET_ADD_WITH_EXTEND_REG,
        CPUET_AND_B_IMM,
        CPUET_AND_B_REG,
        CPUET_AND_W_IMM,
        CPUET_AND_W_REG,
        CPUET_AND_L_IMM,
        CPUET_AND_L_REG,
        CPUET_AND_TO_CONDITION_CODE,
        CPUET_BIT_AND_REG,
        CPUET_BIT_AND_IND,
        CPUET_BIT_AND_ABS,
        CPUET_BRANCH_D8
    } cpuet_instr_t;

    // ------------------------------------------------------------------
    // States per cycle
    // ------------------------------------------------------------------
    localparam logic [ST_W-1:0] CPUET_S_ONCHIP       = 6'h02;
    localparam logic [ST_W-1:0] CPUET_S_MOD8_FETCH   = 6'h06;
    localparam logic [ST_W-1:0] CPUET_S_MOD16        = 6'h03;
    localparam logic [ST_W-1:0] CPUET_S_EXT8_2_FETCH = 6'h04;
    localparam logic [ST_W-1:0] CPUET_S_EXT8_3_FETCH = 6'h06;
    localparam logic [ST_W-1:0] CPUET_S_EXT16_2      = 6'h02;
    localparam logic [ST_W-1:0] CPUET_S_EXT16_3      = 6'h03;
    localparam logic [ST_W-1:0] CPUET_S_MOD8_BYTE    = 6'h03;
    localparam logic [ST_W-1:0] CPUET_S_EXT8_2_BYTE  = 6'h02;
    localparam logic [ST_W-1:0] CPUET_S_EXT8_3_BYTE  = 6'h03;
    localparam logic [ST_W-1:0] CPUET_S_MOD8_WORD    = 6'h06;
    localparam logic [ST_W-1:0] CPUET_S_EXT8_2_WORD  = 6'h04;
    localparam logic [ST_W-1:0] CPUET_S_EXT8_3_WORD  = 6'h06;
    localparam logic [ST_W-1:0] CPUET_S_INTERNAL     = 6'h01;

    // ------------------------------------------------------------------
    // Cycle counts
    // ------------------------------------------------------------------
    localparam logic [CNT_W-1:0] CPUET_CNT_NONE  = 2'h0;
    localparam logic [CNT_W-1:0] CPUET_CNT_ONE   = 2'h1;
    localparam logic [CNT_W-1:0] CPUET_CNT_TWO   = 2'h2;
    localparam logic [CNT_W-1:0] CPUET_CNT_THREE = 2'h3;

endpackage

/* File: design/cpuet_cycle_states.sv */
/*
 * States per cycle lookup for one access condition and wait count.
 * Purely combinational; inputs come from registered logic of the caller.
 */
module cpuet_cycle_states (
    input  wire cpuet_pkg::cpuet_cond_t           cond_i,
    input  wire logic [cpuet_pkg::WAIT_W-1:0]     wait_m_i,
    output logic      [cpuet_pkg::ST_W-1:0]       fetch_states_o,
    output logic      [cpuet_pkg::ST_W-1:0]       byte_states_o,
    output logic      [cpuet_pkg::ST_W-1:0]       word_states_o,
    output logic                                  bad_cond_o
);
    import cpuet_pkg::*;

    logic [ST_W-1:0] m_one;
    logic [ST_W-1:0] m_two;

    // ------------------------------------------------------------------
    // Wait state terms
    // ------------------------------------------------------------------
    assign m_one = ST_W'(wait_m_i);
    assign m_two = ST_W'({wait_m_i, 1'b0});

    // ------------------------------------------------------------------
    // Lookup
    // ------------------------------------------------------------------
    always_comb begin
        fetch_states_o = CPUET_S_ONCHIP;
        byte_states_o  = CPUET_S_ONCHIP;
        word_states_o  = CPUET_S_ONCHIP;
        bad_cond_o     = 1'b0;
        unique case (cond_i)
            CPUET_ONCHIP_MEM: begin
                fetch_states_o = CPUET_S_ONCHIP;
            end
            CPUET_MOD_8BIT: begin
                fetch_states_o = CPUET_S_MOD8_FETCH;
                byte_states_o  = CPUET_S_MOD8_BYTE;
                word_states_o  = CPUET_S_MOD8_WORD;
            end
            CPUET_MOD_16BIT: begin
                fetch_states_o = CPUET_S_MOD16;
                byte_states_o  = CPUET_S_MOD16;
                word_states_o  = CPUET_S_MOD16;
            end
            CPUET_EXT8_2STATE: begin
                fetch_states_o = CPUET_S_EXT8_2_FETCH;
                byte_states_o  = CPUET_S_EXT8_2_BYTE;
                word_states_o  = CPUET_S_EXT8_2_WORD;
            end
            CPUET_EXT8_3STATE: begin
                fetch_states_o = CPUET_S_EXT8_3_FETCH + m_two;
                byte_states_o  = CPUET_S_EXT8_3_BYTE + m_one;
                word_states_o  = CPUET_S_EXT8_3_WORD + m_two;
            end
            CPUET_EXT16_2STATE: begin
                fetch_states_o = CPUET_S_EXT16_2;
                byte_states_o  = CPUET_S_EXT16_2;
                word_states_o  = CPUET_S_EXT16_2;
            end
            CPUET_EXT16_3STATE: begin
                fetch_states_o = CPUET_S_EXT16_3 + m_one;
                byte_states_o  = CPUET_S_EXT16_3 + m_one;
                word_states_o  = CPUET_S_EXT16_3 + m_one;
            end
            default: begin
                bad_cond_o = 1'b1;
            end
        endcase
    end

endmodule // cpuet_cycle_states

/* File: testbench/cpuet_timing_asserts.sv */
/* Concurrent checks on the ports of cpuet_timing.
   Assumes one clock domain and the same STATE_DIV as the bound instance. */
module cpuet_timing_chk #(
    parameter int STATE_DIV = 1
) (
    input wire logic                         core_clk_i,
    input wire logic                         arst_n_i,
    input wire logic                         start_i,
    input wire cpuet_pkg::cpuet_instr_t      instr_i,
    input wire cpuet_pkg::cpuet_cond_t       fetch_cond_i,
    input wire cpuet_pkg::cpuet_cond_t       branch_cond_i,
    input wire cpuet_pkg::cpuet_cond_t       stack_cond_i,
    input wire cpuet_pkg::cpuet_cond_t       data_cond_i,
    input wire logic [cpuet_pkg::WAIT_W-1:0] wait_m_i,
    input wire logic [cpuet_pkg::TOT_W-1:0]  states_o,
    input wire logic [cpuet_pkg::CNT_W-1:0]  fetch_cnt_o,
    input wire logic [cpuet_pkg::CNT_W-1:0]  byte_cnt_o,
    input wire logic                         busy_o,
    input wire logic                         state_tick_o,
    input wire logic                         done_o,
    input wire logic                         err_o
);
    import cpuet_pkg::*;
    // ------------------------------------------------------------------
    // Cycle and tick counters since request
    // ------------------------------------------------------------------
    logic             take;
    logic [TOT_W-1:0] cyc_r;
    logic [TOT_W-1:0] tck_r;
    assign take = start_i && !busy_o;
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cyc_r <= 10'h000;
            tck_r <= 10'h000;
        end else begin
            cyc_r <= take ? 10'h001 : cyc_r + 10'h001;
            tck_r <= take ? 10'h000 : tck_r + {9'h000, state_tick_o};
        end
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    chk_busy_after_start: assert property (take |=> busy_o)
        else $error("busy not raised after start");
    chk_err_clears: assert property (take |=> !err_o)
        else $error("error flag not cleared by start");
    chk_done_latency: assert property (done_o |-> int'(cyc_r) == 2 + int'(states_o) * STATE_DIV)
        else $error("done latency does not match states");
    chk_tick_total: assert property (done_o |-> tck_r + {9'h000, state_tick_o} == states_o)
        else $error("tick count differs from states");
    chk_tick_window: assert property (state_tick_o |-> busy_o || done_o)
        else $error("tick outside a request");
    chk_counts_legal: assert property (done_o && states_o != 0 |->
        fetch_cnt_o != 2'h0 && byte_cnt_o <= 2'h1)
        else $error("cycle counts out of range");
    chk_done_single: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
    chk_busy_ends_done: assert property ($fell(busy_o) |-> done_o)
        else $error("busy fell without done");
    cov_error: cover property (done_o && err_o);
    cov_byte_access: cover property (done_o && byte_cnt_o == 2'h1);
    cov_back_to_back: cover property (done_o && start_i);
endmodule // cpuet_timing_chk

bind cpuet_timing cpuet_timing_chk #(.STATE_DIV(STATE_DIV)) u_chk (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .start_i(start_i), .instr_i(instr_i),
    .fetch_cond_i(fetch_cond_i), .branch_cond_i(branch_cond_i), .stack_cond_i(stack_cond_i),
    .data_cond_i(data_cond_i), .wait_m_i(wait_m_i), .states_o(states_o),
    .fetch_cnt_o(fetch_cnt_o), .byte_cnt_o(byte_cnt_o), .busy_o(busy_o),
    .state_tick_o(state_tick_o), .done_o(done_o), .err_o(err_o));

/* File: testbench/cpuet_bus_env.sv */
/* Access environment model: fetch, stack and data access conditions (branch takes the stack one) and wait count.
   Assumes the bench sets the configuration between requests. */
module cpuet_bus_env (
    input  wire cpuet_pkg::cpuet_cond_t       fcond_i,
    input  wire cpuet_pkg::cpuet_cond_t       scond_i,
    input  wire cpuet_pkg::cpuet_cond_t       dcond_i,
    input  wire logic [cpuet_pkg::WAIT_W-1:0] m_i,
    output cpuet_pkg::cpuet_cond_t            fetch_cond_o,
    output cpuet_pkg::cpuet_cond_t            branch_cond_o,
    output cpuet_pkg::cpuet_cond_t            stack_cond_o,
    output cpuet_pkg::cpuet_cond_t            data_cond_o,
    output logic      [cpuet_pkg::WAIT_W-1:0] wait_m_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import cpuet_pkg::*;
    assign fetch_cond_o  = fcond_i;
    assign branch_cond_o = scond_i;
    assign stack_cond_o  = scond_i;
    assign data_cond_o   = dcond_i;
    assign wait_m_o      = m_i;
endmodule // cpuet_bus_env

/* File: testbench/cpuet_timing_bench.sv */
/* Self-checking bench for cpuet_timing.
   Assumes the checker is bound and the env model supplies conditions. */
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; $display("mismatch t=%0t got=%0h exp=%0h", $time, got, exp); end end
module cpuet_timing_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import cpuet_pkg::*;
    logic              core_clk_i, arst_n_i, start, busy, tick, done, err;
    cpuet_instr_t      ins;
    cpuet_cond_t       fc, sc, dc, f_c, b_c, s_c, d_c;
    logic [WAIT_W-1:0] m, w_m;
    logic [TOT_W-1:0]  states;
    logic [CNT_W-1:0]  fcnt, bcnt;
    int                bad_count, samples_checked, cycles;

    cpuet_bus_env env (.fcond_i(fc), .scond_i(sc), .dcond_i(dc), .m_i(m),
        .fetch_cond_o(f_c), .branch_cond_o(b_c), .stack_cond_o(s_c),
        .data_cond_o(d_c), .wait_m_o(w_m));
    cpuet_timing #(.STATE_DIV(1)) DUT (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
        .start_i(start), .instr_i(ins), .fetch_cond_i(f_c), .branch_cond_i(b_c),
        .stack_cond_i(s_c), .data_cond_i(d_c), .wait_m_i(w_m), .states_o(states),
        .fetch_cnt_o(fcnt), .byte_cnt_o(bcnt), .busy_o(busy), .state_tick_o(tick),
        .done_o(done), .err_o(err));

    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    // ------------------------------------------------------------------
    // Expected states per cycle
    // ------------------------------------------------------------------
    function automatic logic [ST_W-1:0] st(cpuet_cond_t c, logic [WAIT_W-1:0] w, logic byt);
        case (c)
            CPUET_ONCHIP_MEM, CPUET_EXT16_2STATE: st = 6'h02;
            CPUET_MOD_8BIT:     st = byt ? 6'h03 : 6'h06;
            CPUET_MOD_16BIT:    st = 6'h03;
            CPUET_EXT8_2STATE:  st = byt ? 6'h02 : 6'h04;
            CPUET_EXT8_3STATE:  st = byt ? 6'h03 + {2'h0, w} : 6'h06 + {1'h0, w, 1'h0};
            CPUET_EXT16_3STATE: st = 6'h03 + {2'h0, w};
            default:            st = 6'h00;
        endcase
    endfunction
    // ------------------------------------------------------------------
    // One request with its checks
    // ------------------------------------------------------------------
    task automatic op(input cpuet_instr_t i, input cpuet_cond_t f, s, d,
                      input logic [WAIT_W-1:0] w, input logic dup);
        logic [CNT_W-1:0] ei, el;
        logic             ee;
        logic [TOT_W-1:0] et;
        int               n;
        ei = (i inside {CPUET_ADD_W_IMM, CPUET_AND_W_IMM, CPUET_AND_L_REG, CPUET_BIT_AND_IND,
             CPUET_BIT_AND_ABS, CPUET_BRANCH_D8}) ? 2'h2
             : (i inside {CPUET_ADD_L_IMM, CPUET_AND_L_IMM}) ? 2'h3 : 2'h1;
        el = {1'b0, i inside {CPUET_BIT_AND_IND, CPUET_BIT_AND_ABS}};
        ee = (i > CPUET_BRANCH_D8) || (f == 3'h7) || (el != 2'h0 && d == 3'h7);
        et = ee ? 10'h000 : 10'(ei) * 10'(st(f, w, 1'b0)) + 10'(el) * 10'(st(d, w, 1'b1));
        ins = i;
        fc = f;
        sc = s;
        dc = d;
        m = w;
        start = 1'b1;
        @(posedge core_clk_i);
        #1;
        n = 0;
        if (dup) begin
            ins = CPUET_ADD_L_IMM;
            @(posedge core_clk_i);
            #1;
            n = 1;
        end
        start = 1'b0;
        while (done !== 1'b1 && n < 300) begin
            @(posedge core_clk_i);
            #1;
            n++;
        end
        `CHK(n, 1 + int'(et));
        `CHK(states, et);
        `CHK(err, ee);
        `CHK(busy, 1'b0);
        `CHK(tick, !ee);
        if (!ee) begin
            `CHK(fcnt, ei);
            `CHK(bcnt, el);
        end
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_forms();
        for (int k = 0; k < 20; k++) begin
            op(cpuet_instr_t'(k), CPUET_ONCHIP_MEM, CPUET_ONCHIP_MEM, CPUET_MOD_8BIT, 4'h0, 1'b0);
        end
    endtask
    task automatic t_fetch();
        for (int k = 0; k < 7; k++) begin
            op(CPUET_ADD_L_IMM, cpuet_cond_t'(k), cpuet_cond_t'(k), CPUET_ONCHIP_MEM, 4'h3, 1'b0);
        end
        op(CPUET_BRANCH_D8, CPUET_EXT8_3STATE, CPUET_MOD_8BIT, CPUET_MOD_8BIT, 4'hF, 1'b0);
        op(CPUET_ADD_SMALL_CONSTANT, CPUET_EXT16_3STATE, CPUET_MOD_8BIT, CPUET_MOD_8BIT, 4'h1, 1'b0);
    endtask
    task automatic t_byte();
        for (int k = 0; k < 7; k++) begin
            op(CPUET_BIT_AND_ABS, CPUET_MOD_16BIT, CPUET_ONCHIP_MEM, cpuet_cond_t'(k), 4'h2, 1'b0);
        end
        op(CPUET_BIT_AND_IND, CPUET_EXT8_3STATE, CPUET_ONCHIP_MEM, CPUET_EXT8_3STATE, 4'hF, 1'b0);
    endtask
    task automatic t_err();
        op(CPUET_ADD_B_REG, cpuet_cond_t'(7), CPUET_ONCHIP_MEM, CPUET_ONCHIP_MEM, 4'h0, 1'b0);
        op(CPUET_ADD_B_REG, CPUET_MOD_8BIT, cpuet_cond_t'(7), cpuet_cond_t'(7), 4'h0, 1'b0);
        op(CPUET_BIT_AND_IND, CPUET_ONCHIP_MEM, CPUET_ONCHIP_MEM, cpuet_cond_t'(7), 4'h0, 1'b0);
        op(cpuet_instr_t'(5'h1F), CPUET_ONCHIP_MEM, CPUET_ONCHIP_MEM, CPUET_ONCHIP_MEM, 4'h0, 1'b0);
        op(CPUET_BIT_AND_REG, CPUET_MOD_8BIT, CPUET_ONCHIP_MEM, cpuet_cond_t'(7), 4'h0, 1'b0);
    endtask
    task automatic t_refuse();
        op(CPUET_ADD_W_REG, CPUET_EXT8_2STATE, CPUET_ONCHIP_MEM, CPUET_ONCHIP_MEM, 4'h0, 1'b1);
    endtask
    task automatic tally_and_finish();
        $display("comparisons=%0d mismatches=%0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        arst_n_i = 1'b0;
        start = 1'b0;
        ins = CPUET_ADD_B_IMM;
        fc = CPUET_ONCHIP_MEM;
        sc = CPUET_ONCHIP_MEM;
        dc = CPUET_ONCHIP_MEM;
        m = 4'h0;
        bad_count = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (16) @(posedge core_clk_i);
        #1;
        arst_n_i = 1'b1;
        t_forms();
        t_fetch();
        t_byte();
        t_err();
        t_refuse();
        tally_and_finish();
    end
endmodule // cpuet_timing_bench
